// [common/wor_pkg.sv]
package wor_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int           ADDR_W        = 4;
  localparam int           DATA_W        = 16;
  localparam logic [3:0]   REG_CTRL      = 4'h0;
  localparam logic [3:0]   REG_CYCLE     = 4'h1;
  localparam logic [3:0]   REG_BASE      = 4'h2;
  localparam logic [3:0]   REG_EXT       = 4'h3;
  localparam logic [3:0]   REG_CMD       = 4'h4;
  localparam logic [3:0]   REG_STATUS    = 4'h5;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int           CTRL_EN_BIT   = 0;
  localparam int           CTRL_MODE_LO  = 1;
  localparam int           CTRL_MODE_HI  = 2;
  localparam int           CTRL_ARK_BIT  = 3;
  localparam int           CTRL_BANK_BIT = 4;
  localparam logic [1:0]   MODE_WOR      = 2'h1;
  localparam int           MODE_WTM_BIT  = 1;
  localparam logic [15:0]  CYCLE_RST     = 16'h0010;
  localparam logic [10:0]  BASE_RST      = 11'h000;
  localparam logic [15:0]  EXT_RST       = 16'h0000;
  localparam int           BASE_W        = 11;
  localparam int           EXT_W         = 16;
  localparam int           LISTEN_W      = 18;

  // ----------------------------------------------------------------
  // Strobe commands
  // ----------------------------------------------------------------
  localparam logic [15:0]  CMD_IDLE      = 16'h0001;
  localparam logic [15:0]  CMD_SLEEP     = 16'h0002;
  localparam logic [15:0]  CMD_BANK0     = 16'h0003;
  localparam logic [15:0]  CMD_BANK1     = 16'h0004;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int           STEP_TIME_US  = 250;
  localparam int           CLK_MHZ       = 200;
  localparam int           STEP_CYCLES   = STEP_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_IDLE,
    ST_CAL,
    ST_STBY,
    ST_RX,
    ST_TX
  } seq_state_type;

endpackage

// [common/tick_if.sv]
`timescale 1ns/10ps
interface tick_if;
  logic run;
  logic step;
  modport gen  (input run, output step);
  modport user (output run, input step);
endinterface : tick_if

// [core/step_tick_gen.sv]
`timescale 1ns/10ps
module step_tick_gen #(
  parameter int STEP_CYCLES = wor_pkg::STEP_CYCLES,
  parameter int CNT_W       = 16
) (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic ce_in,
  tick_if.gen       tick
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             step;
  } tick_state_type;

  tick_state_type st;
  tick_state_type next_st;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(STEP_CYCLES - 1);

  // The step is a registered pulse so the sequencer sees a clean edge.
  always_comb begin
    next_st      = st;
    next_st.step = 1'b0;
    if (!tick.run) begin
      next_st.cnt = '0;
    end else if (st.cnt == LAST) begin
      next_st.cnt  = '0;
      next_st.step = 1'b1;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign tick.step = st.step;

endmodule // step_tick_gen

// [core/rf_wake_on_rx_sequencer.sv]
`timescale 1ns/10ps
module rf_wake_on_rx_sequencer #(
  parameter int STEP_CYCLES = wor_pkg::STEP_CYCLES
) (
  input  wire logic                        mclk_in,
  input  wire logic                        reset_n_in,
  input  wire logic                        ce_in,
  input  wire logic [wor_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [wor_pkg::DATA_W-1:0]  wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [wor_pkg::DATA_W-1:0]  rdata_out,
  input  wire logic                        preamble_det_in,
  input  wire logic                        sync_det_in,
  input  wire logic                        pkt_done_in,
  input  wire logic                        crc_ok_in,
  input  wire logic                        pid_match_in,
  input  wire logic                        cal_done_in,
  input  wire logic                        tx_done_in,
  output logic                             cal_req_out,
  output logic                             rx_on_out,
  output logic                             tx_on_out,
  output logic                             rx_irq_out,
  output logic                             gio_wave_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    wor_pkg::seq_state_type             state;
    logic                               enable;
    logic [1:0]                         mode;
    logic                               auto_resend_ack;
    logic                               bank;
    logic [15:0]                        cycle_period;
    logic [wor_pkg::BASE_W-1:0]         base_period;
    logic [wor_pkg::EXT_W-1:0]          ext_period;
    logic [15:0]                        cycle_cnt;
    logic [wor_pkg::LISTEN_W-1:0]       listen_cnt;
    logic                               wakeup_timer_mode;
    logic                               sync_seen;
    logic                               ext_used;
    logic                               cal_req;
    logic                               rx_on;
    logic                               tx_on;
    logic                               irq;
    logic                               gio;
    logic [wor_pkg::DATA_W-1:0]         rdata;
  } seq_type;

  seq_type st;
  seq_type next_st;

  tick_if tick ();

  step_tick_gen #(
    .STEP_CYCLES (STEP_CYCLES),
    .CNT_W       (16)
  ) u_tick (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .tick       (tick.gen)
  );

  // The step runs freely during a session, so the first step of a
  // window may come up to one step early; windows are loaded one step
  // longer to cover that.
  assign tick.run = (st.state != wor_pkg::ST_SLEEP);

  function automatic logic is_cmd(input logic             wr,
                                  input logic [3:0]       addr,
                                  input logic [15:0]      data,
                                  input logic [15:0]      code);
    is_cmd = wr && (addr == wor_pkg::REG_CMD) && (data == code);
  endfunction

  logic idle_cmd;
  logic sleep_cmd;
  logic wake;
  logic window_over;

  assign idle_cmd    = is_cmd(wr_in, addr_in, wdata_in, wor_pkg::CMD_IDLE);
  assign sleep_cmd   = is_cmd(wr_in, addr_in, wdata_in, wor_pkg::CMD_SLEEP);
  assign wake        = tick.step && (st.cycle_cnt == 16'h0000);
  assign window_over = (st.listen_cnt == '0);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.irq   = 1'b0;
    next_st.rdata = '0;

    // Register access stays open in every state.
    if (wr_in) begin
      case (addr_in)
        wor_pkg::REG_CTRL: begin
          next_st.enable = wdata_in[wor_pkg::CTRL_EN_BIT];
          next_st.mode   = wdata_in[wor_pkg::CTRL_MODE_HI:wor_pkg::CTRL_MODE_LO];
          next_st.auto_resend_ack    = wdata_in[wor_pkg::CTRL_ARK_BIT];
        end
        wor_pkg::REG_CYCLE: next_st.cycle_period = wdata_in;
        wor_pkg::REG_BASE:  next_st.base_period  = wdata_in[wor_pkg::BASE_W-1:0];
        wor_pkg::REG_EXT:   next_st.ext_period   = wdata_in[wor_pkg::EXT_W-1:0];
        wor_pkg::REG_CMD: begin
          // Unknown command codes fall through untouched.
          if (wdata_in == wor_pkg::CMD_BANK0) begin
            next_st.bank = 1'b0;
          end else if (wdata_in == wor_pkg::CMD_BANK1) begin
            next_st.bank = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        wor_pkg::REG_CTRL:   next_st.rdata = {11'h000, st.bank, st.auto_resend_ack, st.mode, st.enable};
        wor_pkg::REG_CYCLE:  next_st.rdata = st.cycle_period;
        wor_pkg::REG_BASE:   next_st.rdata = {5'h00, st.base_period};
        wor_pkg::REG_EXT:    next_st.rdata = st.ext_period;
        wor_pkg::REG_STATUS: next_st.rdata = {10'h000, st.wakeup_timer_mode, st.ext_used,
                                              st.sync_seen, st.state};
        default:             next_st.rdata = '0;
      endcase
    end

    // Wake-up cycle timer, reloaded in the cycle it expires.
    if (st.state != wor_pkg::ST_SLEEP && tick.step) begin
      if (wake) begin
        next_st.cycle_cnt = st.cycle_period;
      end else begin
        next_st.cycle_cnt = st.cycle_cnt - 16'h0001;
      end
    end

    // Listening window counts down in 250us steps.
    if ((st.state == wor_pkg::ST_RX || st.state == wor_pkg::ST_TX) &&
        tick.step && !window_over) begin
      next_st.listen_cnt = st.listen_cnt - wor_pkg::LISTEN_W'(1);
    end

    case (st.state)
      wor_pkg::ST_SLEEP: begin
        if (idle_cmd && st.enable) begin
          if (st.mode == wor_pkg::MODE_WOR) begin
            next_st.state     = wor_pkg::ST_IDLE;
            next_st.wakeup_timer_mode       = 1'b0;
            next_st.cycle_cnt = st.cycle_period;
          end else if (st.mode[wor_pkg::MODE_WTM_BIT]) begin
            next_st.state     = wor_pkg::ST_IDLE;
            next_st.wakeup_timer_mode       = 1'b1;
            next_st.cycle_cnt = st.cycle_period;
          end
        end
      end
      wor_pkg::ST_IDLE: begin
        if (wake && st.wakeup_timer_mode) begin
          next_st.gio = !st.gio;
        end else if (wake) begin
          next_st.state   = wor_pkg::ST_CAL;
          next_st.cal_req = 1'b1;
        end
      end
      wor_pkg::ST_CAL: begin
        if (cal_done_in) begin
          next_st.state   = wor_pkg::ST_STBY;
          next_st.cal_req = 1'b0;
        end
      end
      wor_pkg::ST_STBY: begin
        next_st.state      = wor_pkg::ST_RX;
        next_st.rx_on      = 1'b1;
        next_st.sync_seen  = 1'b0;
        next_st.ext_used   = 1'b0;
        next_st.listen_cnt = wor_pkg::LISTEN_W'(st.base_period) +
                             wor_pkg::LISTEN_W'(1);
      end
      wor_pkg::ST_RX: begin
        if (pkt_done_in && crc_ok_in && st.sync_seen) begin
          if (!st.auto_resend_ack) begin
            next_st.irq   = 1'b1;
            next_st.state = wor_pkg::ST_SLEEP;
            next_st.rx_on = 1'b0;
          end else begin
            next_st.irq   = !pid_match_in;
            next_st.state = wor_pkg::ST_TX;
            next_st.rx_on = 1'b0;
            next_st.tx_on = 1'b1;
          end
        end else if (pkt_done_in && st.sync_seen) begin
          next_st.sync_seen = 1'b0;
          if (!st.auto_resend_ack) begin
            next_st.state = wor_pkg::ST_IDLE;
            next_st.rx_on = 1'b0;
          end
        end else if (st.sync_seen) begin
          next_st.sync_seen = 1'b1;
        end else if (window_over) begin
          next_st.state = wor_pkg::ST_IDLE;
          next_st.rx_on = 1'b0;
        end else if (sync_det_in) begin
          next_st.sync_seen = 1'b1;
        end else if (preamble_det_in && !st.ext_used) begin
          // One extension per wake keeps the combined mode bounded.
          next_st.ext_used   = 1'b1;
          next_st.listen_cnt = next_st.listen_cnt +
                               wor_pkg::LISTEN_W'(st.ext_period) +
                               wor_pkg::LISTEN_W'(1);
        end
      end
      wor_pkg::ST_TX: begin
        if (tx_done_in) begin
          next_st.tx_on     = 1'b0;
          next_st.sync_seen = 1'b0;
          if (window_over) begin
            next_st.state = wor_pkg::ST_IDLE;
          end else begin
            next_st.state = wor_pkg::ST_RX;
            next_st.rx_on = 1'b1;
          end
        end
      end
      default: next_st.state = wor_pkg::ST_SLEEP;
    endcase

    // Light Sleep overrides every step of a session.
    if (sleep_cmd) begin
      next_st.state   = wor_pkg::ST_SLEEP;
      next_st.wakeup_timer_mode     = 1'b0;
      next_st.cal_req = 1'b0;
      next_st.rx_on   = 1'b0;
      next_st.tx_on   = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st              <= '0;
      st.state        <= wor_pkg::ST_SLEEP;
      st.cycle_period <= wor_pkg::CYCLE_RST;
      st.base_period  <= wor_pkg::BASE_RST;
      st.ext_period   <= wor_pkg::EXT_RST;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign rdata_out    = st.rdata;
  assign cal_req_out  = st.cal_req;
  assign rx_on_out    = st.rx_on;
  assign tx_on_out    = st.tx_on;
  assign rx_irq_out   = st.irq;
  assign gio_wave_out = st.gio;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  logic quiet;
  assign quiet = ce_in && !wr_in;

  sequence s_cal_done;
    ce_in && st.state == wor_pkg::ST_CAL && cal_done_in && !wr_in;
  endsequence

  sequence s_stby;
    ce_in && st.state == wor_pkg::ST_STBY && !wr_in;
  endsequence

  property p_cal_to_rx;
    s_cal_done ##1 s_stby |=> st.state == wor_pkg::ST_RX && rx_on_out &&
      st.listen_cnt == wor_pkg::LISTEN_W'($past(st.base_period)) + wor_pkg::LISTEN_W'(1);
  endproperty
  a_cal_to_rx: assert property (p_cal_to_rx) else $error("calibration path wrong");

  property p_sleep;
    ce_in && sleep_cmd |=> st.state == wor_pkg::ST_SLEEP && !rx_on_out && !tx_on_out &&
      !st.wakeup_timer_mode;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep command not obeyed");

  property p_start_wor;
    ce_in && st.state == wor_pkg::ST_SLEEP && idle_cmd && st.enable &&
      st.mode == wor_pkg::MODE_WOR |=> st.state == wor_pkg::ST_IDLE && !st.wakeup_timer_mode;
  endproperty
  a_start_wor: assert property (p_start_wor) else $error("receive mode not started");

  property p_wake;
    quiet && st.state == wor_pkg::ST_IDLE && !st.wakeup_timer_mode && wake |=>
      st.state == wor_pkg::ST_CAL && cal_req_out && st.cycle_cnt == $past(st.cycle_period);
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not start calibration");

  property p_wtm;
    quiet && st.state == wor_pkg::ST_IDLE && st.wakeup_timer_mode && wake |=>
      gio_wave_out != $past(gio_wave_out) && st.state == wor_pkg::ST_IDLE;
  endproperty
  a_wtm: assert property (p_wtm) else $error("timer mode waveform wrong");

  property p_extend;
    quiet && st.state == wor_pkg::ST_RX && preamble_det_in && !st.ext_used &&
      !sync_det_in && !pkt_done_in && !st.sync_seen && !window_over && !tick.step |=>
      st.listen_cnt == $past(st.listen_cnt) + wor_pkg::LISTEN_W'($past(st.ext_period)) +
      wor_pkg::LISTEN_W'(1) && st.ext_used;
  endproperty
  a_extend: assert property (p_extend) else $error("window not extended");

  property p_hold;
    quiet && st.state == wor_pkg::ST_RX && st.sync_seen && !pkt_done_in |=>
      st.state == wor_pkg::ST_RX && rx_on_out;
  endproperty
  a_hold: assert property (p_hold) else $error("receive dropped after sync");

  property p_expire;
    quiet && st.state == wor_pkg::ST_RX && window_over && !st.sync_seen && !pkt_done_in |=>
      st.state == wor_pkg::ST_IDLE && !rx_on_out;
  endproperty
  a_expire: assert property (p_expire) else $error("window expiry missed");

  property p_plain_done;
    quiet && st.state == wor_pkg::ST_RX && st.sync_seen && pkt_done_in && crc_ok_in &&
      !st.auto_resend_ack |=> rx_irq_out && st.state == wor_pkg::ST_SLEEP ##1
      (!rx_irq_out || !$past(ce_in));
  endproperty
  a_plain_done: assert property (p_plain_done) else $error("plain receive end wrong");

  property p_ark_done;
    quiet && st.state == wor_pkg::ST_RX && st.sync_seen && pkt_done_in && crc_ok_in &&
      st.auto_resend_ack |=> tx_on_out && rx_irq_out == !$past(pid_match_in);
  endproperty
  a_ark_done: assert property (p_ark_done) else $error("acknowledge path wrong");

  property p_ack_back;
    quiet && st.state == wor_pkg::ST_TX && tx_done_in && !window_over |=>
      st.state == wor_pkg::ST_RX && rx_on_out && !tx_on_out;
  endproperty
  a_ack_back: assert property (p_ack_back) else $error("no return to receive");

endmodule // rf_wake_on_rx_sequencer

// [bench/radio_front_model.sv]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Radio front end: answers calibration and acknowledge transmit
// ----------------------------------------------------------------
module radio_front_model #(
  parameter int CAL_DLY = 3,
  parameter int TX_DLY  = 6
) (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic cal_req_in,
  input  wire logic tx_on_in,
  output logic      cal_done_out,
  output logic      tx_done_out
);
  int cal_cnt;
  int tx_cnt;

  // The transmit slot length stands in for the data rate of the acknowledgement.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cal_cnt      <= 0;
      tx_cnt       <= 0;
      cal_done_out <= 1'b0;
      tx_done_out  <= 1'b0;
    end else begin
      cal_cnt      <= cal_req_in ? cal_cnt + 1 : 0;
      tx_cnt       <= tx_on_in ? tx_cnt + 1 : 0;
      cal_done_out <= cal_req_in && (cal_cnt == CAL_DLY);
      tx_done_out  <= tx_on_in && (tx_cnt == TX_DLY);
    end
  end
endmodule // radio_front_model

// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
  localparam int S = 4;
  logic        mclk_in    = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [3:0]  addr_in    = 4'h0;
  logic [15:0] wdata_in   = 16'h0000;
  logic        wr_in = 1'b0, rd_in = 1'b0, pre_in = 1'b0, sync_in = 1'b0;
  logic        done_in = 1'b0, crc_in = 1'b0, pid_in = 1'b0, ce_in = 1'b1;
  logic [15:0] rdata_out;
  logic [15:0] rv;
  logic        cal_req_out, rx_on_out, tx_on_out, rx_irq_out, gio_wave_out;
  logic        cal_done, tx_done;
  logic        rx_q = 1'b0, tx_q = 1'b0, cal_q = 1'b0, cal_q2 = 1'b0, gio_q = 1'b0;
  int          n_fail = 0, n_checks = 0, cyc = 0, n_irq = 0, n_gio = 0, n_end = 0;
  int          run_len = 0, last_len = 0, k = 0;

  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  rf_wake_on_rx_sequencer #(.STEP_CYCLES(S)) dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .preamble_det_in(pre_in), .sync_det_in(sync_in),
    .pkt_done_in(done_in), .crc_ok_in(crc_in), .pid_match_in(pid_in),
    .cal_done_in(cal_done), .tx_done_in(tx_done), .cal_req_out(cal_req_out),
    .rx_on_out(rx_on_out), .tx_on_out(tx_on_out), .rx_irq_out(rx_irq_out),
    .gio_wave_out(gio_wave_out));

  radio_front_model #(.CAL_DLY(3), .TX_DLY(6)) front (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .cal_req_in(cal_req_out),
    .tx_on_in(tx_on_out), .cal_done_out(cal_done), .tx_done_out(tx_done));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi, input int got);
    chk(nm, 16'h0001, 16'(got >= lo && got <= hi));
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1;
    rv = rdata_out;
  endtask

  task automatic st(input logic [15:0] exp);
    rd(wor_pkg::REG_STATUS);
    chk("status", exp, rv & 16'h003F);
  endtask

  // Waiting on the rising receiver keeps the bench free of fixed guesses of wake time.
  task automatic wait_rx(input int lim);
    for (int i = 0; i < lim && rx_on_out !== 1'b1; i++) @(posedge mclk_in) #1;
    chk("rx_on", 16'h0001, {15'h0, rx_on_out});
  endtask

  task automatic wait_end(input int lim);
    int e;
    e = n_end;
    for (int i = 0; i < lim && n_end == e; i++) @(posedge mclk_in) #1;
    chk("session_end", 16'h0001, 16'(n_end != e));
  endtask

  task automatic pkt(input logic crc, input logic pid, input int gap);
    @(posedge mclk_in);
    sync_in <= 1'b1;
    @(posedge mclk_in);
    sync_in <= 1'b0;
    repeat (gap) @(posedge mclk_in);
    #1;
    chk("rx_held", 16'h0001, {15'h0, rx_on_out});
    @(posedge mclk_in);
    done_in <= 1'b1;
    crc_in  <= crc;
    pid_in  <= pid;
    @(posedge mclk_in);
    done_in <= 1'b0;
    crc_in  <= ~crc;
    pid_in  <= ~pid;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (rx_irq_out === 1'b1) n_irq <= n_irq + 1;
    if (gio_wave_out !== gio_q) n_gio <= n_gio + 1;
    if (rx_on_out === 1'b1 && rx_q === 1'b0 && tx_q === 1'b0)
      chk("cal_stby_rx", 16'h0002, {14'h0, cal_q2, cal_q});
    if (rx_on_out === 1'b1 || tx_on_out === 1'b1) run_len <= run_len + 1;
    else if (rx_q === 1'b1 || tx_q === 1'b1) begin
      last_len <= run_len;
      run_len  <= 0;
      n_end    <= n_end + 1;
    end
    rx_q   <= rx_on_out;
    tx_q   <= tx_on_out;
    cal_q  <= cal_req_out;
    cal_q2 <= cal_q;
    gio_q  <= gio_wave_out;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    rd(wor_pkg::REG_CTRL);  chk("ctrl", 16'h0000, rv);
    rd(wor_pkg::REG_CYCLE); chk("cycle", 16'h0010, rv);
    rd(wor_pkg::REG_BASE);  chk("base", 16'h0000, rv);
    rd(wor_pkg::REG_EXT);   chk("ext", 16'h0000, rv);
    rd(4'hF);               chk("unmapped", 16'h0000, rv);
    st(16'h0000);
    wr(wor_pkg::REG_CYCLE, 16'h0001);
    wr(wor_pkg::REG_BASE, 16'h0001);
    wr(wor_pkg::REG_CTRL, 16'h0003);
    wr(wor_pkg::REG_CMD, 16'h0007);
    st(16'h0000);
    wr(wor_pkg::REG_CMD, wor_pkg::CMD_BANK1);
    rd(wor_pkg::REG_CTRL); chk("bank", 16'h0013, rv);
    wr(wor_pkg::REG_CMD, wor_pkg::CMD_BANK0);
    wr(wor_pkg::REG_CMD, wor_pkg::CMD_IDLE);
    st(16'h0001);
    wait_rx(60);
    wait_end(40);
    rng("base_window", S, 2 * S + 2, last_len);
    st(16'h0001);
    wr(wor_pkg::REG_EXT, 16'h0002);
    wait_rx(60);
    @(posedge mclk_in) pre_in <= 1'b1;
    @(posedge mclk_in) pre_in <= 1'b0;
    @(posedge mclk_in) pre_in <= 1'b1;
    @(posedge mclk_in) pre_in <= 1'b0;
    wait_end(60);
    rng("ext_window", 4 * S, 5 * S + 2, last_len);
    st(16'h0011);
    wr(wor_pkg::REG_EXT, 16'h0000);
    wait_rx(60);
    k = n_irq;
    pkt(1'b1, 1'b0, 12);
    @(posedge mclk_in) #1;
    chk("irq", 16'(k + 1), 16'(n_irq));
    st(16'h0008);
    wr(wor_pkg::REG_CMD, wor_pkg::CMD_IDLE);
    st(16'h0009);
    wait_rx(60);
    pkt(1'b0, 1'b0, 0);
    st(16'h0001);
    chk("irq_bad", 16'(k + 1), 16'(n_irq));
    wait_rx(60);
    wr(wor_pkg::REG_CMD, wor_pkg::CMD_SLEEP);
    st(16'h0000);
    chk("rx_off", 16'h0000, {15'h0, rx_on_out});
    wr(wor_pkg::REG_BASE, 16'h0014);
    wr(wor_pkg::REG_CTRL, 16'h000B);
    wr(wor_pkg::REG_CMD, wor_pkg::CMD_IDLE);
    wait_rx(60);
    k = n_irq;
    pkt(1'b1, 1'b0, 0);
    chk("ack_new", 16'h0001, {15'h0, tx_on_out});
    @(posedge mclk_in) #1;
    chk("irq_new", 16'(k + 1), 16'(n_irq));
    wait_rx(30);
    pkt(1'b1, 1'b1, 0);
    chk("ack_rep", 16'h0001, {15'h0, tx_on_out});
    wait_rx(30);
    chk("irq_rep", 16'(k + 1), 16'(n_irq));
    pkt(1'b0, 1'b0, 0);
    chk("bad_stay", 16'h0002, {14'h0, rx_on_out, tx_on_out});
    wait_end(200);
    rng("ack_window", 20 * S, 22 * S + 20, last_len);
    st(16'h0001);
    wr(wor_pkg::REG_CMD, wor_pkg::CMD_SLEEP);
    for (int m = 5; m <= 7; m += 2) begin
      wr(wor_pkg::REG_CTRL, 16'(m));
      wr(wor_pkg::REG_CMD, wor_pkg::CMD_IDLE);
      k = n_gio;
      repeat (48) @(posedge mclk_in);
      #1;
      rng("gio_toggles", 5, 7, n_gio - k);
      st(16'h0021);
      chk("no_rx", 16'h0000, {15'h0, rx_on_out});
      wr(wor_pkg::REG_CMD, 16'h0007);
      st(16'h0021);
      wr(wor_pkg::REG_CMD, wor_pkg::CMD_SLEEP);
      k = n_gio;
      repeat (30) @(posedge mclk_in);
      #1;
      chk("gio_stop", 16'(k), 16'(n_gio));
      st(16'h0000);
    end
    // A low clock enable must hold the timer, so no waveform edge may appear.
    wr(wor_pkg::REG_CMD, wor_pkg::CMD_IDLE);
    @(posedge mclk_in) ce_in <= 1'b0;
    k = n_gio;
    repeat (30) @(posedge mclk_in);
    #1;
    chk("ce_freeze", 16'(k), 16'(n_gio));
    @(posedge mclk_in) ce_in <= 1'b1;
    st(16'h0021);
    conclude();
  end
endmodule // tb
